/* File: rtl/tmc_timer.sv */
// Purpose: Third 16-bit timer with capture, reload and baud modes, plus the shared timer flags.
// Assumes: All pin inputs are synchronous to sys_clk; sys_clk is the oscillator clock.
// Notes:   Avalon-MM slave with one wait state on every access.
`timescale 1ns/10ps

// What this block does
// - Timer a/b overflows set their flags; servicing the interrupt clears them.
// - Timer a/b run bits are software written and drive the run outputs.
// - External interrupt edge flags are set on detection, cleared on service.
// - Type bit set selects falling edge, clear selects low level triggering.
// - Counter and capture/reload value are each a 16-bit low/high byte pair.
// - Mode is off, baud, capture or reload decoded from control bits.
// - Overflow flag set on overflow, cleared by software, never in baud mode.
// - External trigger flag set when an enabled trigger fall acts.
// - Receive clock select picks timer c overflows, else timer b overflows.
// - Transmit clock select picks timer c overflows, else timer b overflows.
// - Trigger events ignored unless enabled; no capture or reload in baud mode.
// - Run bit one counts, zero stops the counter.
// - Source zero counts oscillator over twelve outside baud mode, one counts event input falls.
// - In baud mode overflow always reloads, capture/reload select ignored.
// - Capture mode trigger fall copies counter into capture pair, sets flag.
// - Reload mode overflow sets flag and reloads; enabled trigger fall also reloads.
// - Baud mode overflow reloads counter from the capture/reload pair.
// - Baud mode internal timing prescales the oscillator by two.
// - Baud mode trigger fall only sets the external trigger flag.
// - Interrupt request is raised when enabled and either timer c flag is set.
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int PRE_TIMER = PRESCALE_TIMER,
  parameter int PRE_BAUD  = PRESCALE_BAUD
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire tmc_avs_req_t avs_req,
  output logic              avs_waitrequest,
  output logic [31:0]       avs_readdata,
  input  wire logic         timer_a_ovf,
  input  wire logic         timer_b_ovf,
  input  wire logic         svc_timer_a,
  input  wire logic         svc_timer_b,
  input  wire logic         svc_ext_a,
  input  wire logic         svc_ext_b,
  input  wire logic         ext_irq_a_n,
  input  wire logic         ext_irq_b_n,
  input  wire logic         event_in,
  input  wire logic         trigger_input,
  input  wire logic         timer_c_irq_en,
  output logic [7:0]        run_and_flags,
  output logic              timer_c_irq,
  output logic              rx_clk_pulse,
  output logic              tx_clk_pulse
);

  localparam logic [3:0] MC_LAST = 4'(PRE_TIMER - 1);
  localparam logic [3:0] BD_LAST = 4'(PRE_BAUD - 1);

  function automatic tmc_mode_t mode_f(input logic [7:0] c);
    if (!c[TC_RUN]) begin
      return TMC_OFF;
    end else if (c[TC_RCLK] || c[TC_SERIAL_TX_CLOCK_SELECT]) begin
      return TMC_BAUD;
    end else if (c[TC_CPRL]) begin
      return TMC_CAPTURE;
    end
    return TMC_RELOAD;
  endfunction

  // A fall is a high sample followed by a low one at a machine cycle boundary.
  function automatic logic fall_f(input logic tick, input logic prev, input logic cur);
    return tick && prev && !cur;
  endfunction

  tmc_state_t s_r;
  tmc_state_t s_nxt;
  tmc_mode_t  mode;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic       mc_tick;
  logic       bd_tick;
  logic       trg_fall;
  logic       evt_fall;
  logic       xa_fall;
  logic       xb_fall;
  logic       inc;
  logic       ovf;
  logic       ext_go;

  always_comb begin
    s_nxt = s_r;
    mode = mode_f(s_r.ctl);
    acc = (avs_req.read || avs_req.write) && !s_r.wreq;
    wr = acc && avs_req.write && avs_req.byteenable[0];
    wd = avs_req.writedata[7:0];

    mc_tick = (s_r.mc == MC_LAST);
    bd_tick = (s_r.bd == BD_LAST);
    s_nxt.mc = mc_tick ? '0 : s_r.mc + 4'h1;
    s_nxt.bd = bd_tick ? '0 : s_r.bd + 4'h1;

    trg_fall = fall_f(mc_tick, s_r.trg_smp, trigger_input);
    evt_fall = fall_f(mc_tick, s_r.evt_smp, event_in);
    xa_fall = fall_f(mc_tick, s_r.xa_smp, ext_irq_a_n);
    xb_fall = fall_f(mc_tick, s_r.xb_smp, ext_irq_b_n);
    if (mc_tick) begin
      s_nxt.trg_smp = trigger_input;
      s_nxt.evt_smp = event_in;
      s_nxt.xa_smp = ext_irq_a_n;
      s_nxt.xb_smp = ext_irq_b_n;
    end

    // Baud mode with internal timing uses the short prescaler instead of the machine cycle.
    if (s_r.ctl[TC_SRC]) begin
      inc = evt_fall;
    end else if (mode == TMC_BAUD) begin
      inc = bd_tick;
    end else begin
      inc = mc_tick;
    end
    inc = inc && (mode != TMC_OFF);
    ovf = inc && (s_r.cnt == CNT_ALL_ONES);
    ext_go = trg_fall && s_r.ctl[TC_EXEN] && (mode != TMC_OFF);

    if (inc) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    if (ovf && mode != TMC_CAPTURE) begin
      s_nxt.cnt = s_r.cap;
    end
    if (ext_go && mode == TMC_RELOAD) begin
      s_nxt.cnt = s_r.cap;
    end
    if (ext_go && mode == TMC_CAPTURE) begin
      s_nxt.cap = s_r.cnt;
    end

    // Software writes to the count pair win over counting in the same cycle.
    if (wr) begin
      case (avs_req.address)
        ADDR_RUN_FLAGS: s_nxt.flags = wd;
        ADDR_TC_CTRL:   s_nxt.ctl = wd;
        ADDR_TC_LOW:    s_nxt.cnt[7:0] = wd;
        ADDR_TC_HIGH:   s_nxt.cnt[15:8] = wd;
        ADDR_CR_LOW:    s_nxt.cap[7:0] = wd;
        ADDR_CR_HIGH:   s_nxt.cap[15:8] = wd;
        default: begin
        end
      endcase
    end

    // Hardware sets are applied after software writes so that a set is never lost.
    if (ovf && mode != TMC_BAUD) begin
      s_nxt.ctl[TC_OVF] = 1'b1;
    end
    if (ext_go) begin
      s_nxt.ctl[TC_EXF] = 1'b1;
    end

    if (svc_timer_a) begin
      s_nxt.flags[RF_TA_OVF] = 1'b0;
    end
    if (svc_timer_b) begin
      s_nxt.flags[RF_TB_OVF] = 1'b0;
    end
    if (timer_a_ovf) begin
      s_nxt.flags[RF_TA_OVF] = 1'b1;
    end
    if (timer_b_ovf) begin
      s_nxt.flags[RF_TB_OVF] = 1'b1;
    end

    // A level-type flag simply follows the sampled pin, so servicing cannot clear it.
    if (s_r.flags[RF_XA_TYPE]) begin
      if (svc_ext_a) begin
        s_nxt.flags[RF_XA_FLAG] = 1'b0;
      end
      if (xa_fall) begin
        s_nxt.flags[RF_XA_FLAG] = 1'b1;
      end
    end else if (mc_tick) begin
      s_nxt.flags[RF_XA_FLAG] = !ext_irq_a_n;
    end
    if (s_r.flags[RF_XB_TYPE]) begin
      if (svc_ext_b) begin
        s_nxt.flags[RF_XB_FLAG] = 1'b0;
      end
      if (xb_fall) begin
        s_nxt.flags[RF_XB_FLAG] = 1'b1;
      end
    end else if (mc_tick) begin
      s_nxt.flags[RF_XB_FLAG] = !ext_irq_b_n;
    end

    s_nxt.rx_pls = s_r.ctl[TC_RCLK] ? ovf : timer_b_ovf;
    s_nxt.tx_pls = s_r.ctl[TC_SERIAL_TX_CLOCK_SELECT] ? ovf : timer_b_ovf;
    s_nxt.irq = timer_c_irq_en && (s_r.ctl[TC_OVF] || s_r.ctl[TC_EXF]);

    // One wait state: the request is answered in the cycle after it is seen.
    if ((avs_req.read || avs_req.write) && s_r.wreq) begin
      s_nxt.wreq = 1'b0;
      case (avs_req.address)
        ADDR_RUN_FLAGS: s_nxt.rdata = s_r.flags;
        ADDR_TC_CTRL:   s_nxt.rdata = s_r.ctl;
        ADDR_TC_LOW:    s_nxt.rdata = s_r.cnt[7:0];
        ADDR_TC_HIGH:   s_nxt.rdata = s_r.cnt[15:8];
        ADDR_CR_LOW:    s_nxt.rdata = s_r.cap[7:0];
        ADDR_CR_HIGH:   s_nxt.rdata = s_r.cap[15:8];
        default:        s_nxt.rdata = 8'h00;
      endcase
    end else begin
      s_nxt.wreq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest = s_r.wreq;
  assign avs_readdata = {24'h000000, s_r.rdata};
  assign run_and_flags = s_r.flags;
  assign timer_c_irq = s_r.irq;
  assign rx_clk_pulse = s_r.rx_pls;
  assign tx_clk_pulse = s_r.tx_pls;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_ta_flag;
    timer_a_ovf |=> run_and_flags[RF_TA_OVF];
  endproperty
  a_ta_flag: assert property (p_ta_flag) else $error("timer a flag not set");

  property p_run_write;
    wr && avs_req.address == ADDR_RUN_FLAGS |=> run_and_flags[RF_TB_RUN] == $past(wd[RF_TB_RUN]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit not written");

  property p_edge_flag;
    s_r.flags[RF_XA_TYPE] && xa_fall |=> run_and_flags[RF_XA_FLAG];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag missed");

  property p_level_flag;
    !s_r.flags[RF_XB_TYPE] && mc_tick && !ext_irq_b_n |=> run_and_flags[RF_XB_FLAG];
  endproperty
  a_level_flag: assert property (p_level_flag) else $error("level flag missed");

  property p_no_ovf_baud;
    mode == TMC_BAUD && !s_r.ctl[TC_OVF] && !wr |=> !s_r.ctl[TC_OVF];
  endproperty
  a_no_ovf_baud: assert property (p_no_ovf_baud) else $error("overflow flag set in baud");

  property p_capture;
    ext_go && mode == TMC_CAPTURE && !wr |=> s_r.cap == $past(s_r.cnt) && s_r.ctl[TC_EXF];
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_reload;
    ovf && mode == TMC_RELOAD && !wr |=> s_r.cnt == $past(s_r.cap) && s_r.ctl[TC_OVF];
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");

  property p_rx_route;
    s_r.ctl[TC_RCLK] && ovf |-> ##1 rx_clk_pulse;
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx pulse missing");

  property p_irq;
    timer_c_irq_en && s_r.ctl[TC_EXF] |=> timer_c_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_machine_cycle;
    inc && mode == TMC_RELOAD && !s_r.ctl[TC_SRC] |=> (!inc || mode == TMC_BAUD) [*8];
  endproperty
  a_machine_cycle: assert property (p_machine_cycle) else $error("count faster than cycle");

  property p_one_wait;
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");

  property p_ext_flag;
    ext_go && mode != TMC_BAUD |=> s_r.ctl[TC_EXF];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("external flag not set");

  property p_baud_trig;
    ext_go && mode == TMC_BAUD && !wr |=> s_r.ctl[TC_EXF] && s_r.cap == $past(s_r.cap);
  endproperty
  a_baud_trig: assert property (p_baud_trig) else $error("baud trigger misused");

  property p_tx_route;
    s_r.ctl[TC_SERIAL_TX_CLOCK_SELECT] && ovf |=> tx_clk_pulse;
  endproperty
  a_tx_route: assert property (p_tx_route) else $error("tx pulse missing");

  property p_rx_alt;
    !s_r.ctl[TC_RCLK] |=> rx_clk_pulse == $past(timer_b_ovf);
  endproperty
  a_rx_alt: assert property (p_rx_alt) else $error("rx pulse not from timer b");

  property p_trig_ignored;
    trg_fall && !s_r.ctl[TC_EXEN] && !s_r.ctl[TC_EXF] && !wr |=> !s_r.ctl[TC_EXF];
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

  property p_stopped;
    mode == TMC_OFF && !wr |=> s_r.cnt == $past(s_r.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while off");

  property p_baud_cprl;
    ovf && mode == TMC_BAUD && s_r.ctl[TC_CPRL] && !wr |=> s_r.cnt == $past(s_r.cap);
  endproperty
  a_baud_cprl: assert property (p_baud_cprl) else $error("baud ignored reload");

  property p_baud_reload;
    ovf && mode == TMC_BAUD && !s_r.ctl[TC_CPRL] && !wr |=> s_r.cnt == $past(s_r.cap);
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("baud reload failed");

  // Holds for the default baud prescale of two.
  property p_baud_rate;
    inc && mode == TMC_BAUD && !s_r.ctl[TC_SRC] && !wr |=>
      !inc ##1 (inc || mode != TMC_BAUD || s_r.ctl[TC_SRC]);
  endproperty
  a_baud_rate: assert property (p_baud_rate) else $error("baud step rate wrong");

  property p_sample;
    mc_tick |=> s_r.trg_smp == $past(trigger_input);
  endproperty
  a_sample: assert property (p_sample) else $error("trigger sample wrong");

  property p_evt_count;
    evt_fall && s_r.ctl[TC_SRC] && mode == TMC_RELOAD && !ext_go && !wr &&
      s_r.cnt != CNT_ALL_ONES |=> s_r.cnt == $past(s_r.cnt) + 16'h0001;
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("event not counted");

  property p_mode_baud;
    s_r.ctl[TC_RUN] && (s_r.ctl[TC_RCLK] || s_r.ctl[TC_SERIAL_TX_CLOCK_SELECT]) |-> mode == TMC_BAUD;
  endproperty
  a_mode_baud: assert property (p_mode_baud) else $error("baud mode not decoded");

  property p_xa_svc;
    s_r.flags[RF_XA_TYPE] && svc_ext_a && !xa_fall && !wr |=> !run_and_flags[RF_XA_FLAG];
  endproperty
  a_xa_svc: assert property (p_xa_svc) else $error("edge flag not cleared");

  property p_ta_svc;
    svc_timer_a && !timer_a_ovf && !wr |=> !run_and_flags[RF_TA_OVF];
  endproperty
  a_ta_svc: assert property (p_ta_svc) else $error("timer a flag not cleared");

  property p_irq_low;
    !s_r.ctl[TC_OVF] && !s_r.ctl[TC_EXF] |=> !timer_c_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq without flag");

  property p_ta_run;
    wr && avs_req.address == ADDR_RUN_FLAGS |=> run_and_flags[RF_TA_RUN] == $past(wd[RF_TA_RUN]);
  endproperty
  a_ta_run: assert property (p_ta_run) else $error("timer a run bit not written");

  property p_ovf_clear;
    wr && avs_req.address == ADDR_TC_CTRL && !wd[TC_OVF] && !ovf |=> !s_r.ctl[TC_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_ext_reload;
    ext_go && mode == TMC_RELOAD && !wr |=> s_r.cnt == $past(s_r.cap) && s_r.ctl[TC_EXF];
  endproperty
  a_ext_reload: assert property (p_ext_reload) else $error("trigger reload failed");

  c_capture: cover property (ext_go && mode == TMC_CAPTURE);
  c_baud_ovf: cover property (ovf && mode == TMC_BAUD);
  c_reload_ovf: cover property (ovf && mode == TMC_RELOAD);
  c_ext_reload: cover property (ext_go && mode == TMC_RELOAD);
  c_baud_trig: cover property (ext_go && mode == TMC_BAUD);

endmodule

/* File: inc/tmc_pkg.sv */
// Purpose: Shared constants and types of the timer_c block and the shared timer flag register.
// Assumes: Registers are one 8-bit value in the low byte of an aligned 32-bit word.
// Notes:   All offsets are byte addresses on the register bus.
package tmc_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RUN_FLAGS = 8'h88;
  localparam logic [ADDR_W-1:0] ADDR_TC_CTRL   = 8'hC8;
  localparam logic [ADDR_W-1:0] ADDR_TC_LOW    = 8'hCC;
  localparam logic [ADDR_W-1:0] ADDR_TC_HIGH   = 8'hD0;
  localparam logic [ADDR_W-1:0] ADDR_CR_LOW    = 8'hD4;
  localparam logic [ADDR_W-1:0] ADDR_CR_HIGH   = 8'hD8;

  // Bits of timer_run_and_irq_flags.
  localparam int RF_TB_OVF  = 7;
  localparam int RF_TB_RUN  = 6;
  localparam int RF_TA_OVF  = 5;
  localparam int RF_TA_RUN  = 4;
  localparam int RF_XB_FLAG = 3;
  localparam int RF_XB_TYPE = 2;
  localparam int RF_XA_FLAG = 1;
  localparam int RF_XA_TYPE = 0;

  // Bits of timer_three_control.
  localparam int TC_OVF  = 7;
  localparam int TC_EXF  = 6;
  localparam int TC_RCLK = 5;
  localparam int TC_SERIAL_TX_CLOCK_SELECT = 4;
  localparam int TC_EXEN = 3;
  localparam int TC_RUN  = 2;
  localparam int TC_SRC  = 1;
  localparam int TC_CPRL = 0;

  localparam logic [7:0]  RUN_FLAGS_RST = 8'h00;
  localparam logic [7:0]  TC_CTRL_RST   = 8'h00;
  localparam logic [15:0] CNT_ALL_ONES  = 16'hFFFF;
  localparam int          PRESCALE_TIMER = 12;
  localparam int          PRESCALE_BAUD  = 2;

  typedef enum logic [1:0] {TMC_OFF, TMC_RELOAD, TMC_CAPTURE, TMC_BAUD} tmc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } tmc_avs_req_t;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  ctl;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [3:0]  mc;
    logic [3:0]  bd;
    logic        trg_smp;
    logic        evt_smp;
    logic        xa_smp;
    logic        xb_smp;
    logic        wreq;
    logic [7:0]  rdata;
    logic        rx_pls;
    logic        tx_pls;
    logic        irq;
  } tmc_state_t;

  localparam tmc_state_t STATE_RST = '{flags: RUN_FLAGS_RST, ctl: TC_CTRL_RST, wreq: 1'b1,
                                       trg_smp: 1'b1, evt_smp: 1'b1, xa_smp: 1'b1,
                                       xb_smp: 1'b1, default: '0};

endpackage

/* File: verif/tmc_pin_model.sv */
// Purpose: Model of the pins that face the timer block: trigger, event and interrupt inputs.
// Assumes: Pins idle high as if pulled up; every change lands just after a rising edge.
// Notes:   The bench sets each level and keeps it for at least one machine cycle.
`timescale 1ns/10ps
module tmc_pin_model (
  input  wire logic sys_clk,
  output logic      trigger_input,
  output logic      event_in,
  output logic      ext_irq_a_n,
  output logic      ext_irq_b_n
);
  logic [3:0] pins_r;

  initial pins_r = 4'hF;
  assign {ext_irq_b_n, ext_irq_a_n, event_in, trigger_input} = pins_r;

  // A level shorter than a machine cycle could be missed by the sampler, so the task holds it for 15 clocks.
  task automatic drive(input int which, input logic lvl);
    pins_r[which] <= lvl;
    repeat (15) @(posedge sys_clk);
  endtask
endmodule

/* File: verif/timer2_and_timer_flags_tb_top.sv */
// Purpose: Self-checking bench of the timer_c block and the shared timer flag register.
// Assumes: Register bus answers with waitrequest low; pins come from the pin model.
// Notes:   Each scenario is its own task and judges what it sees before returning.
`timescale 1ns/10ps
module timer2_and_timer_flags_tb_top;
  import tmc_pkg::*;
  logic sys_clk, srst, ta_ovf, svc_a, svc_x, irq_en, wreq, irq, rxp, txp;
  logic trg, evt, xa_n, xb_n;
  tmc_avs_req_t req;
  logic [31:0] rdata;
  logic [7:0] flags, rd;
  int miscompares, samples_checked, cyc;

  tmc_timer u_tmc_timer (.sys_clk(sys_clk), .srst(srst), .avs_req(req),
    .avs_waitrequest(wreq), .avs_readdata(rdata), .timer_a_ovf(ta_ovf),
    .timer_b_ovf(1'b0), .svc_timer_a(svc_a), .svc_timer_b(1'b0), .svc_ext_a(svc_x),
    .svc_ext_b(1'b0), .ext_irq_a_n(xa_n), .ext_irq_b_n(xb_n), .event_in(evt),
    .trigger_input(trg), .timer_c_irq_en(irq_en), .run_and_flags(flags),
    .timer_c_irq(irq), .rx_clk_pulse(rxp), .tx_clk_pulse(txp));
  tmc_pin_model u_tmc_pin_model (.sys_clk(sys_clk), .trigger_input(trg), .event_in(evt),
    .ext_irq_a_n(xa_n), .ext_irq_b_n(xb_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // The whole run needs well under 2000 cycles; a hang ends it here.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // The request is held until an edge samples waitrequest low; read data is taken there.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}, byteenable: 4'h1};
    do @(posedge sys_clk); while (wreq !== 1'b0);
    rd = rdata[7:0];
    req <= '{address: a, read: 1'b0, write: 1'b0, writedata: {24'h0, d}, byteenable: 4'h1};
    @(posedge sys_clk);
  endtask

  task automatic t_reset();
    bus(8'h88, 1'b0, 8'h00); check(rd, 8'h00);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h00);
    bus(8'hE0, 1'b0, 8'h00); check(rd, 8'h00);
  endtask

  task automatic t_flags();
    bus(8'h88, 1'b1, 8'h50); tick(1); check(flags, 8'h50);
    ta_ovf <= 1'b1; tick(1); ta_ovf <= 1'b0; tick(2); check(flags, 8'h70);
    svc_a <= 1'b1; tick(1); svc_a <= 1'b0; tick(2); check(flags, 8'h50);
  endtask

  task automatic t_ext();
    bus(8'h88, 1'b1, 8'h01);
    u_tmc_pin_model.drive(2, 1'b0); tick(15);
    u_tmc_pin_model.drive(2, 1'b1);
    bus(8'h88, 1'b0, 8'h00); check(rd, 8'h03);
    svc_x <= 1'b1; tick(1); svc_x <= 1'b0; tick(2); check(flags, 8'h01);
    bus(8'h88, 1'b1, 8'h00); bus(8'h88, 1'b0, 8'h00); check(rd, 8'h00);
    u_tmc_pin_model.drive(2, 1'b0); tick(15);
    bus(8'h88, 1'b0, 8'h00); check(rd, 8'h02);
    u_tmc_pin_model.drive(2, 1'b1); tick(15);
  endtask

  task automatic t_reload();
    bus(8'hCC, 1'b1, 8'hFE); bus(8'hD0, 1'b1, 8'hFF);
    bus(8'hD4, 1'b1, 8'h34); bus(8'hD8, 1'b1, 8'h12);
    bus(8'hC8, 1'b1, 8'h04); tick(30);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h84);
    check(irq, 1'b1);
    bus(8'hD0, 1'b0, 8'h00); check(rd, 8'h12);
    bus(8'hC8, 1'b1, 8'h00); tick(2); check(irq, 1'b0);
    bus(8'hCC, 1'b1, 8'h77); tick(40); bus(8'hCC, 1'b0, 8'h00); check(rd, 8'h77);
  endtask

  task automatic t_capture();
    bus(8'hCC, 1'b1, 8'h00); bus(8'hD0, 1'b1, 8'h56); bus(8'hC8, 1'b1, 8'h0D);
    u_tmc_pin_model.drive(0, 1'b0); tick(15); u_tmc_pin_model.drive(0, 1'b1);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h4D);
    bus(8'hD8, 1'b0, 8'h00); check(rd, 8'h56);
    bus(8'hC8, 1'b1, 8'h05);
    u_tmc_pin_model.drive(0, 1'b0); tick(15); u_tmc_pin_model.drive(0, 1'b1);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h05);
  endtask

  task automatic t_event();
    bus(8'hC8, 1'b1, 8'h06); bus(8'hCC, 1'b1, 8'h00); bus(8'hD0, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_tmc_pin_model.drive(1, 1'b0); tick(15); u_tmc_pin_model.drive(1, 1'b1); tick(15);
    end
    bus(8'hCC, 1'b0, 8'h00); check(rd, 8'h03);
    bus(8'hC8, 1'b1, 8'h0E);
    u_tmc_pin_model.drive(0, 1'b0); tick(15); u_tmc_pin_model.drive(0, 1'b1);
    bus(8'hD0, 1'b0, 8'h00); check(rd, 8'h56);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h4E);
  endtask

  task automatic count_pulses(input logic [7:0] ctl, input int exp_rx, input int exp_tx);
    int nrx;
    int ntx;
    nrx = 0;
    ntx = 0;
    bus(8'hC8, 1'b1, ctl); tick(8);
    repeat (40) begin
      @(posedge sys_clk);
      nrx += (rxp === 1'b1);
      ntx += (txp === 1'b1);
    end
    check(nrx, exp_rx);
    check(ntx, exp_tx);
  endtask

  task automatic t_baud();
    bus(8'hD4, 1'b1, 8'hFE); bus(8'hD8, 1'b1, 8'hFF);
    bus(8'hCC, 1'b1, 8'hFE); bus(8'hD0, 1'b1, 8'hFF);
    // Two steps of two clocks each from FFFE to rollover: one pulse every 4 clocks.
    count_pulses(8'h35, 10, 10);
    count_pulses(8'h2D, 10, 0);
    u_tmc_pin_model.drive(0, 1'b0); tick(15); u_tmc_pin_model.drive(0, 1'b1);
    bus(8'hC8, 1'b0, 8'h00); check(rd, 8'h6D);
    bus(8'hD4, 1'b0, 8'h00); check(rd, 8'hFE);
    count_pulses(8'h1C, 0, 10);
  endtask

  initial begin
    srst = 1'b1;
    ta_ovf = 1'b0;
    svc_a = 1'b0;
    svc_x = 1'b0;
    irq_en = 1'b1;
    req = '{address: 8'h00, read: 1'b0, write: 1'b0, writedata: 32'h0, byteenable: 4'h1};
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    tick(3);
    srst <= 1'b0;
    tick(1);
    t_reset();
    t_flags();
    t_ext();
    t_reload();
    t_capture();
    t_event();
    t_baud();
    end_sim();
  end
endmodule
